// file: bcd_arith_pkg.sv
// constants, register map, encodings and carrier types of the decimal arithmetic unit
package bcd_arith_pkg;
	// word and character layout
	localparam int DATA_W     = 24;
	localparam int CHAR_W     = 6;
	localparam int DIGIT_W    = 4;
	localparam int ACC_DIGITS = 13;
	localparam int MEM_ADDR_W = 15;
	localparam int CHAR_ADDR_W = MEM_ADDR_W + 2;
	localparam int SHIFT_DIR_BIT = 23;
	localparam int FAULT_BIT  = 9;
	localparam logic [3:0] DIGIT_MAX  = 4'h9;
	localparam logic [3:0] DIGIT_BASE = 4'hA;
	localparam logic [3:0] MAX_LEN    = 4'hC;
	localparam logic [3:0] LAST_DIGIT = 4'hC;
	localparam logic [1:0] NEG_SIGN   = 2'h2;
	localparam logic [1:0] NO_SIGN    = 2'h0;
	// register byte offsets
	localparam logic [11:0] OFF_CMD     = 12'h000;
	localparam logic [11:0] OFF_OPERAND = 12'h004;
	localparam logic [11:0] OFF_INDEX   = 12'h008;
	localparam logic [11:0] OFF_LEN     = 12'h00C;
	localparam logic [11:0] OFF_STATUS  = 12'h010;
	localparam logic [11:0] OFF_SENSE   = 12'h014;
	localparam logic [11:0] OFF_ACC_LO  = 12'h018;
	localparam logic [11:0] OFF_ACC_HI  = 12'h01C;
	localparam logic [11:0] OFF_CTRL    = 12'h020;
	// command word fields
	localparam int CMD_OP_LSB    = 0;
	localparam int CMD_INDEX_BIT = 3;
	localparam int CMD_DESIG_BIT = 4;
	localparam int CMD_W         = 5;
	// status word bits
	localparam int ST_BUSY  = 0;
	localparam int ST_TAKEN = 1;
	localparam int ST_SIGN  = 2;
	localparam int ST_OVF   = 3;
	localparam int ST_TRAP  = 4;
	localparam int ACC_LO_DIGITS = 8;
	typedef enum logic [2:0] {
		set_length_op           = 3'h0,
		decimal_shift_op        = 3'h1,
		accum_test_branch       = 3'h2,
		decimal_overflow_branch = 3'h3,
		decimal_load_op         = 3'h4,
		decimal_store_op        = 3'h5,
		decimal_sum_op          = 3'h6,
		decimal_minus_op        = 3'h7
	} dec_op_t;
	typedef enum logic [2:0] {
		S_IDLE   = 3'h0,
		S_READ   = 3'h1,
		S_WRITE  = 3'h2,
		S_ARITH  = 3'h3,
		S_RECOMP = 3'h4
	} eng_state_t;
	typedef struct packed {
		logic                  req;
		logic                  we;
		logic [MEM_ADDR_W-1:0] addr;
		logic [DATA_W-1:0]     wdata;
	} mem_cmd_t;
endpackage

// file: bcd_char_arith_unit.sv
// decimal character arithmetic unit: accumulator, length register, storage engine, apb slave
//
// How it works
// - storage words are four 6-bit slots, digit low, sign designator high
// - sign rides with least significant digit; upper bits 10 mean negative
// - nonzero upper bits on any other digit slot is a misplaced sign
// - most significant digit sits at lowest character address, rest follow
// - accumulator holds twelve digits, an overflow digit and a sign
// - length register is 4 bits, legal values 1 to 12
// - digits above 9 are illegal on load, store and adder inputs
// - fault sets on misplaced sign, illegal digit, or set-length above 12
// - sensing the fault clears the fault indicator
// - length 13 stores thirteen digits; load, add, subtract use twelve
// - shift moves whole digits; count is operand plus index when the index bit is 1, bits 0-3, 23
// - bit 23 zero shifts left, one shifts right, end off, no wrap
// - magnitude is low 4 bits of sum, or of its complement for right
// - test branch: designator 0 tests zero, 1 tests negative
// - overflow branch taken when the thirteenth digit holds a digit
// - set-length copies low 4 bits of operand, kept until rewritten
// - field address adds the index register only when the index bit is 1
// - load reads least significant first, back to base for lengths up to 12; sign from first digit
// - store writes least significant with sign first, shifting right end off
// - add sums a stored field of up to twelve digits into accumulator
// - subtract takes a stored field from accumulator, same addressing as add
// - in trap mode the decimal commands trap to software instead of running
// - fault reported as interrupt condition bit 9, cleared when sensed
`timescale 1ns/1ps
module bcd_char_arith_unit (
	input  wire logic                     CLK,
	input  wire logic                     RESET,
	input  wire logic                     CE,
	input  wire logic                     PSEL,
	input  wire logic                     PENABLE,
	input  wire logic                     PWRITE,
	input  wire logic [11:0]              PADDR,
	input  wire logic [31:0]              PWDATA,
	output logic      [31:0]              PRDATA,
	output logic                          PREADY,
	output logic                          PSLVERR,
	output bcd_arith_pkg::mem_cmd_t       MEM_CMD,
	input  wire logic [23:0]              MEM_RDATA,
	input  wire logic                     MEM_ACK,
	output logic                          DEC_FAULT,
	output logic                          BRANCH_TAKEN
);
	import bcd_arith_pkg::*;

	// architectural and engine state
	eng_state_t                          state, next_state;
	logic [ACC_DIGITS-1:0][DIGIT_W-1:0]  acc, next_acc;
	logic                                sign, next_sign;
	logic [3:0]                          len, next_len;
	logic                                fault, next_fault;
	logic                                taken, next_taken;
	logic                                trap, next_trap;
	logic                                trap_en, next_trap_en;
	logic [DATA_W-1:0]                   operand, next_operand;
	logic [DATA_W-1:0]                   index, next_index;
	logic [CMD_W-1:0]                    cmd, next_cmd;
	dec_op_t                             op, next_op;
	logic [CHAR_ADDR_W-1:0]              base, next_base;
	logic [3:0]                          cnt, next_cnt;
	logic [3:0]                          n, next_n;
	logic [ACC_DIGITS-2:0][DIGIT_W-1:0]  opd, next_opd;
	logic                                opd_sign, next_opd_sign;
	logic                                carry, next_carry;
	mem_cmd_t                            mem, next_mem;
	logic [31:0]                         prdata, next_prdata;
	logic                                pready, next_pready;
	logic                                pslverr, next_pslverr;

	// combinational helpers
	logic                   apb_take;
	logic                   apb_done;
	logic                   start;
	logic                   set_fault;
	logic                   clr_fault;
	logic [DATA_W-1:0]      eff_addr;
	logic [DATA_W-1:0]      shift_sum;
	logic [3:0]             shift_mag;
	logic [CHAR_ADDR_W-1:0] char_addr;
	logic [CHAR_W-1:0]      ch;
	logic [DIGIT_W-1:0]     a_dig;
	logic [DIGIT_W-1:0]     b_dig;
	logic [DIGIT_W:0]       sum;
	logic                   eff_sub;
	logic [31:0]            rd_word;

	// one slot of a word: slot 0 is the highest six bits
	function automatic logic [CHAR_W-1:0] get_slot(input logic [DATA_W-1:0] w,
			input logic [1:0] s);
		return w[DATA_W-1-CHAR_W*s -: CHAR_W];
	endfunction

	function automatic logic [DATA_W-1:0] put_slot(input logic [DATA_W-1:0] w,
			input logic [1:0] s, input logic [CHAR_W-1:0] c);
		logic [DATA_W-1:0] r;
		r = w;
		r[DATA_W-1-CHAR_W*s -: CHAR_W] = c;
		return r;
	endfunction

	// apb handshake and read mux
	always_comb begin
		apb_take = PSEL & PENABLE & ~pready;
		apb_done = PSEL & PENABLE & pready;
		rd_word = 32'h0;
		unique case (PADDR)
			OFF_CMD:     rd_word = 32'(cmd);
			OFF_OPERAND: rd_word = 32'(operand);
			OFF_INDEX:   rd_word = 32'(index);
			OFF_LEN:     rd_word = 32'(len);
			OFF_STATUS: begin
				rd_word[ST_BUSY]   = (state != S_IDLE);
				rd_word[ST_TAKEN]  = taken;
				rd_word[ST_SIGN]   = sign;
				rd_word[ST_OVF]    = (acc[ACC_DIGITS-1] != '0);
				rd_word[ST_TRAP]   = trap;
				rd_word[FAULT_BIT] = fault;
			end
			OFF_SENSE:   rd_word[FAULT_BIT] = fault;
			OFF_ACC_LO:  rd_word = acc[ACC_LO_DIGITS-1:0];
			OFF_ACC_HI:  rd_word = 32'({sign, acc[ACC_DIGITS-1:ACC_LO_DIGITS]});
			OFF_CTRL:    rd_word = 32'(trap_en);
			default:     rd_word = 32'h0;
		endcase
	end

	// address arithmetic; eff_addr is used only as a command is taken, so index bit is off the bus
	always_comb begin
		eff_addr  = operand + (PWDATA[CMD_INDEX_BIT] ? index : '0);
		shift_sum = eff_addr;
		shift_mag = shift_sum[SHIFT_DIR_BIT] ? ~shift_sum[3:0] : shift_sum[3:0];
		char_addr = base + CHAR_ADDR_W'(len) - CHAR_ADDR_W'(1) - CHAR_ADDR_W'(cnt);
		ch        = get_slot(MEM_RDATA, char_addr[1:0]);
		a_dig     = acc[cnt];
		b_dig     = (cnt < LAST_DIGIT) ? opd[cnt] : '0;
		eff_sub   = (op == decimal_minus_op) ^ sign ^ opd_sign;
	end

	// next-state computation for bus registers and the engine
	always_comb begin
		next_state    = state;
		next_acc      = acc;
		next_sign     = sign;
		next_len      = len;
		next_taken    = taken;
		next_trap     = trap;
		next_trap_en  = trap_en;
		next_operand  = operand;
		next_index    = index;
		next_cmd      = cmd;
		next_op       = op;
		next_base     = base;
		next_cnt      = cnt;
		next_n        = n;
		next_opd      = opd;
		next_opd_sign = opd_sign;
		next_carry    = carry;
		next_mem      = mem;
		next_prdata   = prdata;
		next_pready   = apb_take;
		next_pslverr  = 1'b0;
		start         = 1'b0;
		set_fault     = 1'b0;
		clr_fault     = 1'b0;
		sum           = '0;

		// register access: answer one cycle into the access phase
		if (apb_take) begin
			next_prdata = PWRITE ? 32'h0 : rd_word;
			if (!PWRITE && PADDR == OFF_SENSE) begin
				clr_fault = 1'b1;
			end
			unique case (PADDR)
				OFF_CMD, OFF_OPERAND, OFF_INDEX, OFF_CTRL:
					next_pslverr = PWRITE & (state != S_IDLE);
				OFF_LEN, OFF_STATUS, OFF_SENSE, OFF_ACC_LO, OFF_ACC_HI:
					next_pslverr = PWRITE;
				default:
					next_pslverr = 1'b1;
			endcase
		end
		if (apb_done && PWRITE && !pslverr) begin
			unique case (PADDR)
				OFF_CMD: begin
					next_cmd = PWDATA[CMD_W-1:0];
					start    = 1'b1;
				end
				OFF_OPERAND: next_operand = PWDATA[DATA_W-1:0];
				OFF_INDEX:   next_index = PWDATA[DATA_W-1:0];
				OFF_CTRL:    next_trap_en = PWDATA[0];
				default:     next_trap_en = trap_en;
			endcase
		end

		unique case (state)
			S_IDLE: begin
				if (start && trap_en) begin
					next_trap = 1'b1;
				end else if (start) begin
					next_trap = 1'b0;
					next_op   = dec_op_t'(PWDATA[CMD_OP_LSB +: 3]);
					unique case (dec_op_t'(PWDATA[CMD_OP_LSB +: 3]))
						set_length_op: begin
							next_len = operand[3:0];
							if (operand[3:0] > MAX_LEN) begin
								set_fault = 1'b1;
							end
						end
						decimal_shift_op: begin
							if (shift_sum[SHIFT_DIR_BIT]) begin
								next_acc = acc >> (DIGIT_W * shift_mag);
							end else begin
								next_acc = acc << (DIGIT_W * shift_mag);
							end
						end
						accum_test_branch: begin
							if (PWDATA[CMD_DESIG_BIT]) begin
								next_taken = sign;
							end else begin
								next_taken = (acc == '0);
							end
						end
						decimal_overflow_branch:
							next_taken = (acc[ACC_DIGITS-1] != '0);
						default: begin
							next_base  = eff_addr[CHAR_ADDR_W-1:0];
							next_cnt   = '0;
							next_carry = 1'b0;
							next_opd   = '0;
							if (dec_op_t'(PWDATA[CMD_OP_LSB +: 3]) == decimal_store_op) begin
								next_n = len;
							end else begin
								next_n = (len > MAX_LEN) ? MAX_LEN : len;
							end
							if (dec_op_t'(PWDATA[CMD_OP_LSB +: 3]) == decimal_load_op) begin
								next_acc  = '0;
								next_sign = 1'b0;
							end
							if (len != '0) begin
								next_state = S_READ;
							end
						end
					endcase
				end
			end
			S_READ: begin
				// fetch the word holding the current character
				next_mem.req  = ~(mem.req & MEM_ACK);
				next_mem.we   = 1'b0;
				next_mem.addr = char_addr[CHAR_ADDR_W-1:2];
				if (mem.req && MEM_ACK) begin
					if (op == decimal_store_op) begin
						if (acc[0] > DIGIT_MAX) begin
							set_fault = 1'b1;
						end
						next_mem.wdata = put_slot(MEM_RDATA, char_addr[1:0],
							{(cnt == '0 && sign) ? NEG_SIGN : NO_SIGN, acc[0]});
						next_state = S_WRITE;
					end else begin
						if (ch[DIGIT_W-1:0] > DIGIT_MAX) begin
							set_fault = 1'b1;
						end
						if (cnt != '0 && ch[CHAR_W-1:DIGIT_W] != NO_SIGN) begin
							set_fault = 1'b1;
						end
						if (op == decimal_load_op) begin
							next_acc[cnt] = ch[DIGIT_W-1:0];
							if (cnt == '0) begin
								next_sign = (ch[CHAR_W-1:DIGIT_W] == NEG_SIGN);
							end
						end else begin
							next_opd[cnt] = ch[DIGIT_W-1:0];
							if (cnt == '0) begin
								next_opd_sign = (ch[CHAR_W-1:DIGIT_W] == NEG_SIGN);
							end
						end
						next_cnt = cnt + 4'h1;
						if (cnt == n - 4'h1) begin
							next_cnt   = '0;
							next_state = (op == decimal_load_op) ? S_IDLE : S_ARITH;
						end
					end
				end
			end
			S_WRITE: begin
				// write back the word with the stored character merged in
				next_mem.req = ~(mem.req & MEM_ACK);
				next_mem.we  = ~(mem.req & MEM_ACK);
				if (mem.req && MEM_ACK) begin
					next_acc   = acc >> DIGIT_W;
					next_cnt   = cnt + 4'h1;
					next_state = (cnt == n - 4'h1) ? S_IDLE : S_READ;
				end
			end
			S_ARITH: begin
				// one digit per cycle, signed magnitude via add or ten's complement
				if (cnt < LAST_DIGIT && a_dig > DIGIT_MAX) begin
					set_fault = 1'b1;
				end
				if (!eff_sub) begin
					sum = {1'b0, a_dig} + {1'b0, b_dig} + 5'(carry);
					next_carry = (sum > 5'(DIGIT_MAX));
					next_acc[cnt] = next_carry ? 4'(sum - 5'(DIGIT_BASE)) : sum[3:0];
				end else begin
					sum = {1'b0, b_dig} + 5'(carry);
					next_carry = ({1'b0, a_dig} < sum);
					next_acc[cnt] = next_carry ? 4'(a_dig + DIGIT_BASE - sum[3:0])
						: 4'(a_dig - sum[3:0]);
				end
				next_cnt = cnt + 4'h1;
				if (cnt == LAST_DIGIT) begin
					next_cnt   = '0;
					next_state = S_IDLE;
					if (eff_sub && next_carry) begin
						next_carry = 1'b0;
						next_sign  = ~sign;
						next_state = S_RECOMP;
					end
				end
			end
			S_RECOMP: begin
				// negate the borrowed result back to a magnitude
				sum = {1'b0, a_dig} + 5'(carry);
				next_carry = (sum != '0);
				next_acc[cnt] = next_carry ? 4'(DIGIT_BASE - sum[3:0]) : '0;
				next_cnt = cnt + 4'h1;
				if (cnt == LAST_DIGIT) begin
					next_cnt   = '0;
					next_state = S_IDLE;
				end
			end
			default: next_state = S_IDLE;
		endcase
		next_fault = (fault & ~clr_fault) | set_fault;
	end

	// registers, frozen while the clock enable is low
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state    <= S_IDLE;
			acc      <= '0;
			sign     <= 1'b0;
			len      <= '0;
			fault    <= 1'b0;
			taken    <= 1'b0;
			trap     <= 1'b0;
			trap_en  <= 1'b0;
			operand  <= '0;
			index    <= '0;
			cmd      <= '0;
			op       <= set_length_op;
			base     <= '0;
			cnt      <= '0;
			n        <= '0;
			opd      <= '0;
			opd_sign <= 1'b0;
			carry    <= 1'b0;
			mem      <= '0;
			prdata   <= '0;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
		end else if (CE) begin
			state    <= next_state;
			acc      <= next_acc;
			sign     <= next_sign;
			len      <= next_len;
			fault    <= next_fault;
			taken    <= next_taken;
			trap     <= next_trap;
			trap_en  <= next_trap_en;
			operand  <= next_operand;
			index    <= next_index;
			cmd      <= next_cmd;
			op       <= next_op;
			base     <= next_base;
			cnt      <= next_cnt;
			n        <= next_n;
			opd      <= next_opd;
			opd_sign <= next_opd_sign;
			carry    <= next_carry;
			mem      <= next_mem;
			prdata   <= next_prdata;
			pready   <= next_pready;
			pslverr  <= next_pslverr;
		end
	end

	// outputs straight from flip-flops
	assign PRDATA       = prdata;
	assign PREADY       = pready;
	assign PSLVERR      = pslverr;
	assign MEM_CMD      = mem;
	assign DEC_FAULT    = fault;
	assign BRANCH_TAKEN = taken;
endmodule

// file: bcd_char_arith_unit_assertions.sv
// port-level assertions for the decimal arithmetic unit
`timescale 1ns/1ps
module bcd_char_arith_unit_checker
	import bcd_arith_pkg::*;
(
	input wire logic                    CLK,
	input wire logic                    RESET,
	input wire logic                    CE,
	input wire logic                    PSEL,
	input wire logic                    PENABLE,
	input wire logic                    PWRITE,
	input wire logic [11:0]             PADDR,
	input wire logic [31:0]             PWDATA,
	input wire logic [31:0]             PRDATA,
	input wire logic                    PREADY,
	input wire logic                    PSLVERR,
	input wire bcd_arith_pkg::mem_cmd_t MEM_CMD,
	input wire logic [23:0]             MEM_RDATA,
	input wire logic                    MEM_ACK,
	input wire logic                    DEC_FAULT,
	input wire logic                    BRANCH_TAKEN
);
	logic sense_rd;
	logic sense_take;
	logic wr_done;
	// first access cycle of a sense read: the edge where the flag is cleared
	assign sense_take = PSEL && PENABLE && !PREADY && !PWRITE && PADDR == OFF_SENSE;
	// completed sense read and completed apb write
	assign sense_rd = PSEL && PENABLE && PREADY && !PWRITE && PADDR == OFF_SENSE;
	assign wr_done  = PSEL && PENABLE && PREADY && PWRITE;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	chk_ready_wait: assert property (CE && PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("pready missing after the wait state");
	chk_ready_pulse: assert property (CE && PREADY |=> !PREADY)
		else $error("pready held longer than one cycle");
	chk_ce_freeze: assert property (!CE |=> $stable(MEM_CMD) && $stable(DEC_FAULT) && $stable(PREADY))
		else $error("outputs moved while clock enable low");
	chk_req_hold: assert property (MEM_CMD.req && !MEM_ACK |=> $stable(MEM_CMD))
		else $error("storage request changed before acknowledge");
	chk_req_gap: assert property (CE && MEM_CMD.req && MEM_ACK |=> !MEM_CMD.req)
		else $error("storage request not dropped after acknowledge");
	chk_fault_sticky: assert property (DEC_FAULT && !sense_take |=> DEC_FAULT)
		else $error("fault flag cleared without a sense read");
	chk_fault_clear: assert property (CE && sense_rd && !MEM_CMD.req |=> !DEC_FAULT)
		else $error("fault flag survived a sense read");
	chk_fault_report: assert property (sense_rd && $past(DEC_FAULT) |-> PRDATA[FAULT_BIT])
		else $error("sense read missed the fault bit");
	chk_branch_cause: assert property ($changed(BRANCH_TAKEN) |-> $past(wr_done) || $past(wr_done, 2))
		else $error("branch result changed without a command");
endmodule

// file: bcd_storage_model.sv
// behavioural word storage answering the unit's storage requests
`timescale 1ns/1ps
module bcd_storage_model
	import bcd_arith_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    reset,
	input  wire logic                    ce,
	input  wire logic [3:0]              slow,
	input  wire bcd_arith_pkg::mem_cmd_t cmd,
	output logic [23:0]                  rdata,
	output logic                         ack
);
	logic [DATA_W-1:0] mem [0:15];
	logic [3:0]        wait_cnt;
	// answer after slow idle cycles; stalls with the unit while ce is low
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ack <= 1'b0;
			wait_cnt <= 4'h0;
			rdata <= 24'h000000;
		end else if (ce) begin
			if (cmd.req && !ack && wait_cnt >= slow) begin
				ack <= 1'b1;
				wait_cnt <= 4'h0;
				rdata <= mem[cmd.addr[3:0]];
				if (cmd.we) begin
					mem[cmd.addr[3:0]] <= cmd.wdata;
				end
			end else begin
				ack <= 1'b0;
				rdata <= ~rdata; // released data keeps toggling
				if (cmd.req && !ack) begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
		end
	end
endmodule

// file: bcd_char_arith_unit_tb_top.sv
// self-checking bench for the decimal arithmetic unit against a storage model
`timescale 1ns/1ps
module bcd_char_arith_unit_tb_top;
	import bcd_arith_pkg::*;
	logic        CLK, RESET, CE, PSEL, PENABLE, PWRITE;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic        PREADY, PSLVERR, MEM_ACK, DEC_FAULT, BRANCH_TAKEN;
	logic [23:0] MEM_RDATA;
	mem_cmd_t    MEM_CMD;
	logic [3:0]  mem_slow;
	int          err_count, check_count, cycles;

	bcd_char_arith_unit i_dut (.CLK(CLK), .RESET(RESET), .CE(CE), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_CMD(MEM_CMD),
		.MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .DEC_FAULT(DEC_FAULT),
		.BRANCH_TAKEN(BRANCH_TAKEN));
	bcd_storage_model i_mem (.clk(CLK), .reset(RESET), .ce(CE), .slow(mem_slow),
		.cmd(MEM_CMD), .rdata(MEM_RDATA), .ack(MEM_ACK));

	// clock and hang guard
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 30000) begin
			err_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; result taken at the edge where pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		// pready is read at the rising edge, before the slave updates it
		do begin
			@(posedge CLK);
		end while (PREADY !== 1'b1);
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic        e;
		apb(w, a, d, q, e);
		if (!w) begin
			check("read data", x, q & m);
		end
		check("slave error", {31'h0, xe}, {31'h0, e});
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 32'h0, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
		xfer(1'b0, a, 32'h0, m, x, 1'b0);
	endtask

	task automatic wait_idle();
		logic [31:0] q;
		logic        e;
		do begin
			apb(1'b0, OFF_STATUS, 32'h0, q, e);
		end while (q[ST_BUSY] !== 1'b0);
	endtask

	task automatic run(input dec_op_t op, input logic ix, input logic dg, input logic [23:0] v);
		wr(OFF_OPERAND, {8'h00, v});
		wr(OFF_CMD, {27'h0, dg, ix, op});
		wait_idle();
	endtask

	task automatic flag(input string what, input logic x, input logic got);
		check(what, {31'h0, x}, {31'h0, got});
	endtask

	// length register, fault on over-long length, sense clearing, refusals
	task automatic t_length();
		run(set_length_op, 1'b0, 1'b0, 24'h000005);
		rd(OFF_LEN, 32'hF, 32'h5);
		flag("fault", 1'b0, DEC_FAULT);
		run(set_length_op, 1'b0, 1'b0, 24'h00000D);
		flag("fault", 1'b1, DEC_FAULT);
		rd(OFF_SENSE, 32'h200, 32'h200);
		rd(OFF_SENSE, 32'h200, 32'h0);
		xfer(1'b1, OFF_LEN, 32'h3, 32'h0, 32'h0, 1'b1);
		xfer(1'b0, 12'h040, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
	endtask

	// indexed negative load with slow storage, busy refusal and a clock-enable stall
	task automatic t_load();
		mem_slow <= 4'h3;
		run(set_length_op, 1'b0, 1'b0, 24'h000003);
		wr(OFF_INDEX, 32'h1);
		wr(OFF_OPERAND, 32'h4);
		wr(OFF_CMD, {27'h0, 1'b0, 1'b1, decimal_load_op});
		xfer(1'b1, OFF_CMD, 32'h0, 32'h0, 32'h0, 1'b1);
		CE <= 1'b0;
		repeat (3) @(posedge CLK);
		CE <= 1'b1;
		wait_idle();
		rd(OFF_ACC_LO, 32'hFFFFFFFF, 32'h00000123);
		rd(OFF_ACC_HI, 32'hFFFFFFFF, 32'h00100000);
		run(accum_test_branch, 1'b0, 1'b1, 24'h0);
		flag("negative branch", 1'b1, BRANCH_TAKEN);
		run(accum_test_branch, 1'b0, 1'b0, 24'h0);
		flag("zero branch", 1'b0, BRANCH_TAKEN);
		mem_slow <= 4'h0;
	endtask

	// four-digit store over a filled word
	task automatic t_store();
		run(set_length_op, 1'b0, 1'b0, 24'h000004);
		run(decimal_store_op, 1'b0, 1'b0, 24'h00000C);
		check("stored word", 32'h000010A3, {8'h00, i_mem.mem[3]});
	endtask

	// twelve nines plus one overflows into the thirteenth digit, then back
	task automatic t_arith();
		run(set_length_op, 1'b0, 1'b0, 24'h00000C);
		run(decimal_load_op, 1'b0, 1'b0, 24'h000010);
		rd(OFF_ACC_HI, 32'hFFFFFFFF, 32'h00009999);
		run(set_length_op, 1'b0, 1'b0, 24'h000001);
		run(decimal_sum_op, 1'b0, 1'b0, 24'h000005);
		rd(OFF_ACC_LO, 32'hFFFFFFFF, 32'h0);
		rd(OFF_ACC_HI, 32'hFFFFFFFF, 32'h00010000);
		rd(OFF_STATUS, 32'h8, 32'h8);
		run(decimal_overflow_branch, 1'b0, 1'b0, 24'h0);
		flag("overflow branch", 1'b1, BRANCH_TAKEN);
		run(decimal_minus_op, 1'b0, 1'b0, 24'h000005);
		rd(OFF_ACC_LO, 32'hFFFFFFFF, 32'h99999999);
		run(decimal_overflow_branch, 1'b0, 1'b0, 24'h0);
		flag("overflow branch", 1'b0, BRANCH_TAKEN);
	endtask

	// right by complement, left through the index, left off the end
	task automatic t_shift();
		run(decimal_shift_op, 1'b0, 1'b0, 24'hFFFFF9);
		rd(OFF_ACC_LO, 32'hFFFFFFFF, 32'h00999999);
		run(decimal_shift_op, 1'b1, 1'b0, 24'h000001);
		rd(OFF_ACC_LO, 32'hFFFFFFFF, 32'h99999900);
		run(decimal_shift_op, 1'b0, 1'b0, 24'h00000F);
		run(accum_test_branch, 1'b0, 1'b0, 24'h0);
		flag("zero branch", 1'b1, BRANCH_TAKEN);
	endtask

	// illegal digit and misplaced sign both raise the fault
	task automatic t_fault();
		run(decimal_load_op, 1'b0, 1'b0, 24'h00001C);
		flag("fault", 1'b1, DEC_FAULT);
		rd(OFF_SENSE, 32'h200, 32'h200);
		run(set_length_op, 1'b0, 1'b0, 24'h000002);
		run(decimal_load_op, 1'b0, 1'b0, 24'h000007);
		flag("fault", 1'b1, DEC_FAULT);
		rd(OFF_SENSE, 32'h200, 32'h200);
	endtask

	// borrowing subtract with recomplement, then a thirteen-digit length
	task automatic t_long();
		run(decimal_minus_op, 1'b0, 1'b0, 24'h000010);
		rd(OFF_ACC_LO, 32'hFFFFFFFF, 32'h00000069);
		rd(OFF_ACC_HI, 32'hFFFFFFFF, 32'h00100000);
		run(set_length_op, 1'b0, 1'b0, 24'h00000D);
		rd(OFF_SENSE, 32'h200, 32'h200);
		run(decimal_load_op, 1'b0, 1'b0, 24'h00000F);
		flag("fault", 1'b0, DEC_FAULT);
		rd(OFF_ACC_LO, 32'hFFFFFFFF, 32'h99999999);
		rd(OFF_ACC_HI, 32'hFFFFFFFF, 32'h00009999);
		run(decimal_store_op, 1'b0, 1'b0, 24'h000020);
		check("stored word", 32'h00009249, {8'h00, i_mem.mem[8]});
	endtask

	// trap mode turns a command into a trap indication only
	task automatic t_trap();
		wr(OFF_CTRL, 32'h1);
		wr(OFF_CMD, {27'h0, 2'b00, decimal_store_op});
		rd(OFF_STATUS, 32'h11, 32'h10);
		check("untouched word", 32'h000010A3, {8'h00, i_mem.mem[3]});
		wr(OFF_CTRL, 32'h0);
	endtask

	// main sequence
	initial begin
		RESET = 1'b1;
		CE = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h000;
		PWDATA = 32'h0;
		mem_slow = 4'h0;
		err_count = 0;
		check_count = 0;
		cycles = 0;
		i_mem.mem[1] = 24'h0010A3;
		i_mem.mem[2] = 24'h000000;
		i_mem.mem[3] = 24'hFFFFFF;
		i_mem.mem[4] = 24'h249249;
		i_mem.mem[5] = 24'h249249;
		i_mem.mem[6] = 24'h249249;
		i_mem.mem[7] = 24'h280000;
		repeat (3) @(posedge CLK);
		RESET <= 1'b0;
		t_length();
		t_load();
		t_store();
		t_arith();
		t_shift();
		t_fault();
		t_long();
		t_trap();
		stop_test();
	end
endmodule

bind bcd_char_arith_unit bcd_char_arith_unit_checker i_chk (.CLK(CLK), .RESET(RESET), .CE(CE),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_CMD(MEM_CMD),
	.MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .DEC_FAULT(DEC_FAULT),
	.BRANCH_TAKEN(BRANCH_TAKEN));
